// [shared/abc_pkg.sv]
// Shared constants, register map and carrier types of the converter back-end control.
package abc_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_BURST = 8'h04;
    localparam logic [7:0] OFF_DCO = 8'h08;
    localparam logic [7:0] OFF_OVR = 8'h0C;
    localparam logic [7:0] OFF_CLK = 8'h10;
    localparam logic [7:0] OFF_DRV = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // Field positions.
    localparam int MODE_BURST_BIT = 0;
    localparam int MODE_STREAM_BIT = 1;
    localparam int MODE_RES_BIT = 2;
    localparam int MODE_SRST_BIT = 3;
    localparam int DCO_EN_BIT = 0;
    localparam int DCO_BW_LSB = 1;
    localparam int OVR_THR_LSB = 0;
    localparam int OVR_HOLD_LSB = 8;
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_PHASE_LSB = 4;
    localparam int DRV_SWING_LSB = 0;
    localparam int DRV_DEEMPH_LSB = 4;

    // Values after reset.
    localparam logic [4:0] RST_EXP = 5'h0A;
    localparam logic [7:0] RST_OVR_THR = 8'hFF;
    localparam logic [1:0] RST_HOLD = 2'h0;
    localparam logic [1:0] RST_DIV = 2'h0;
    localparam logic [3:0] RST_PHASE = 4'h0;
    localparam logic [2:0] RST_SWING = 3'h0;
    localparam logic [2:0] RST_DEEMPH = 3'h0;

    // Burst exponent limits.
    localparam logic [4:0] EXP_MIN = 5'h0A;
    localparam logic [4:0] EXP_MAX = 5'h19;

    // Output resolutions in bits.
    localparam logic [3:0] RES_HI_CFG0 = 4'hE;
    localparam logic [3:0] RES_HI_CFG1 = 4'hC;
    localparam logic [3:0] RES_LO = 4'h9;

    // Phase counter width: 3 * 2^25 fits in 27 bits.
    localparam int CNT_W = 27;

    // Cycles from accepted trigger to the first high-resolution sample.
    localparam int TRIG_DELAY_CYC = 4;

    // Offset filter shift for bandwidth code 0; each code step adds two.
    localparam int DCO_SHIFT_BASE = 10;

    // Over-range threshold step is 128 codes.
    localparam int OVR_STEP_SHIFT = 7;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } abc_req_t;

    typedef struct packed {
        logic [15:0] data_a;
        logic [15:0] data_b;
        logic flag;
        logic [3:0] res_bits;
    } abc_samp_t;

    typedef enum logic [2:0] {
        BS_OFF,
        BS_INIT_LO,
        BS_WAIT,
        BS_DELAY,
        BS_HI,
        BS_LO
    } abc_bstate_t;

endpackage

// [verilog/abc_ovr_chan.sv]
// Over-range detector of one channel with its own hold counter.
`timescale 1ns/1ps
module abc_ovr_chan (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Settings
    input wire logic enable,
    input wire logic [7:0] thr_code,
    input wire logic [3:0] hold_cyc,
    // Core sample
    input wire logic signed [15:0] sample,
    // Flag
    output logic ovr_ff
);
    logic [16:0] limit;
    logic [16:0] mag;
    logic over;
    logic [3:0] cnt_ff;

    // Threshold code c selects a magnitude limit of (c + 1) * 128 codes.
    assign limit = 17'({9'(thr_code) + 9'h001, 7'h00});
    assign mag = sample[15] ? 17'(-{sample[15], sample}) : 17'({1'b0, sample});
    assign over = enable && (mag >= limit);

    // Detection reads the raw core sample, ahead of all pipeline stages.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (!enable) begin
            ovr_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (over) begin
            ovr_ff <= 1'b1;
            cnt_ff <= 4'h0;
        end else if (ovr_ff) begin
            if (cnt_ff == hold_cyc) begin
                ovr_ff <= 1'b0;
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end

    chk_ovr_rise: assert property (@(posedge clk) disable iff (!rst_n)
        over |=> ovr_ff) else $error("over-range flag did not rise");

    chk_hold_three: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(over) && ovr_ff && hold_cyc == 4'h3) ##1 (!over && enable)[*3]
        |-> ovr_ff ##1 !ovr_ff) else $error("hold of three cycles wrong");

    chk_hold_zero: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(over) && ovr_ff && hold_cyc == 4'h0) |=> !ovr_ff)
        else $error("zero hold did not release at once");

endmodule // abc_ovr_chan

// [verilog/abc_top.sv]
// Back-end control of a dual-channel converter: burst sequencer, filter, over-range, clock.
`timescale 1ns/1ps
module abc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire abc_pkg::abc_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Pins from the system
    input wire logic burst_trigger,
    input wire logic sysref,
    // Core samples, same clock
    input wire logic signed [15:0] core_a,
    input wire logic signed [15:0] core_b,
    // Sample stream towards the framer
    output abc_pkg::abc_samp_t samp_out,
    // Pins to the system
    output logic trigger_ready,
    output logic overrange_out_a,
    output logic overrange_out_b,
    // Clock and driver settings
    output logic [3:0] clock_divide_factor,
    output logic [3:0] phase_select,
    output logic link_reinit,
    output logic phase_realign,
    output logic [2:0] swing_select,
    output logic [2:0] deemphasis_select
);
    logic rst_s1_ff, rst_n;
    logic trig_s1_ff, trig_s2_ff, trig_s3_ff, trig_rise;
    logic sref_s1_ff, sref_s2_ff, sref_s3_ff, sref_rise;
    logic burst_en_ff, stream_ff, res_cfg_ff, soft_rst_ff;
    logic [2:0] prev_mode_ff;
    logic restart;
    logic [4:0] exp_ff;
    logic dco_en_ff;
    logic [1:0] dco_bw_ff;
    logic [7:0] ovr_thr_ff;
    logic [1:0] hold_sel_ff;
    logic [3:0] hold_cyc;
    logic [1:0] div_ff;
    logic [3:0] phase_ff, phase_max;
    logic [2:0] swing_ff, deemph_ff;
    logic wr_mode, wr_clk;
    logic [4:0] wexp;
    abc_pkg::abc_bstate_t state_ff;
    logic [abc_pkg::CNT_W-1:0] cnt_ff, hi_len, lo_len;
    logic signed [15:0] core_in [2];
    logic signed [15:0] filt [2];

    // Reset release through two flops; assertion stays asynchronous.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n <= rst_s1_ff;
        end
    end

    // Pin synchronisers; the edge detectors look only at the second stage onward.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_s1_ff <= 1'b0;
            trig_s2_ff <= 1'b0;
            trig_s3_ff <= 1'b0;
            sref_s1_ff <= 1'b0;
            sref_s2_ff <= 1'b0;
            sref_s3_ff <= 1'b0;
        end else begin
            trig_s1_ff <= burst_trigger;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            sref_s1_ff <= sysref;
            sref_s2_ff <= sref_s1_ff;
            sref_s3_ff <= sref_s2_ff;
        end
    end

    assign trig_rise = trig_s2_ff && !trig_s3_ff;
    assign sref_rise = sref_s2_ff && !sref_s3_ff;

    assign wr_mode = reg_req.wr && (reg_req.addr == abc_pkg::OFF_MODE);
    assign wr_clk = reg_req.wr && (reg_req.addr == abc_pkg::OFF_CLK);
    assign wexp = reg_req.wdata[4:0];

    // Mode register and soft reset pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_en_ff <= 1'b0;
            stream_ff <= 1'b0;
            res_cfg_ff <= 1'b0;
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_mode && reg_req.wdata[abc_pkg::MODE_SRST_BIT];
            if (wr_mode) begin
                burst_en_ff <= reg_req.wdata[abc_pkg::MODE_BURST_BIT];
                stream_ff <= reg_req.wdata[abc_pkg::MODE_STREAM_BIT];
                res_cfg_ff <= reg_req.wdata[abc_pkg::MODE_RES_BIT];
            end
        end
    end

    // Remaining configuration registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_ff <= abc_pkg::RST_EXP;
            dco_en_ff <= 1'b0;
            dco_bw_ff <= 2'h0;
            ovr_thr_ff <= abc_pkg::RST_OVR_THR;
            hold_sel_ff <= abc_pkg::RST_HOLD;
            div_ff <= abc_pkg::RST_DIV;
            phase_ff <= abc_pkg::RST_PHASE;
            swing_ff <= abc_pkg::RST_SWING;
            deemph_ff <= abc_pkg::RST_DEEMPH;
        end else if (reg_req.wr) begin
            unique case (reg_req.addr)
                abc_pkg::OFF_BURST: begin
                    // Out-of-range exponents are clamped into 10..25.
                    if (wexp < abc_pkg::EXP_MIN) begin
                        exp_ff <= abc_pkg::EXP_MIN;
                    end else if (wexp > abc_pkg::EXP_MAX) begin
                        exp_ff <= abc_pkg::EXP_MAX;
                    end else begin
                        exp_ff <= wexp;
                    end
                end
                abc_pkg::OFF_DCO: begin
                    dco_en_ff <= reg_req.wdata[abc_pkg::DCO_EN_BIT];
                    dco_bw_ff <= reg_req.wdata[abc_pkg::DCO_BW_LSB +: 2];
                end
                abc_pkg::OFF_OVR: begin
                    ovr_thr_ff <= reg_req.wdata[abc_pkg::OVR_THR_LSB +: 8];
                    hold_sel_ff <= reg_req.wdata[abc_pkg::OVR_HOLD_LSB +: 2];
                end
                abc_pkg::OFF_CLK: begin
                    div_ff <= reg_req.wdata[abc_pkg::CLK_DIV_LSB +: 2];
                    phase_ff <= reg_req.wdata[abc_pkg::CLK_PHASE_LSB +: 4];
                end
                abc_pkg::OFF_DRV: begin
                    swing_ff <= reg_req.wdata[abc_pkg::DRV_SWING_LSB +: 3];
                    deemph_ff <= reg_req.wdata[abc_pkg::DRV_DEEMPH_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands in the cycle after the read strobe only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (!reg_req.rd) begin
            reg_rdata <= 32'h0;
        end else begin
            unique case (reg_req.addr)
                abc_pkg::OFF_MODE:
                    reg_rdata <= 32'({res_cfg_ff, stream_ff, burst_en_ff});
                abc_pkg::OFF_BURST: reg_rdata <= 32'(exp_ff);
                abc_pkg::OFF_DCO: reg_rdata <= 32'({dco_bw_ff, dco_en_ff});
                abc_pkg::OFF_OVR: reg_rdata <= 32'({hold_sel_ff, ovr_thr_ff});
                abc_pkg::OFF_CLK: reg_rdata <= 32'({phase_ff, 2'h0, div_ff});
                abc_pkg::OFF_DRV: reg_rdata <= 32'({1'b0, deemph_ff, 1'b0, swing_ff});
                abc_pkg::OFF_STATUS:
                    reg_rdata <= 32'({overrange_out_b, overrange_out_a,
                                      trigger_ready, samp_out.flag});
                default: reg_rdata <= 32'h0;
            endcase
        end
    end

    // Low phase is 2^N*(1/k-1): three high phases at quarter duty, one at half.
    assign hi_len = abc_pkg::CNT_W'(1) << exp_ff;
    assign lo_len = res_cfg_ff ? hi_len : (hi_len << 1) + hi_len;

    // Any change of burst enable, sub-mode or resolution counts as a mode change.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_mode_ff <= 3'h0;
        end else begin
            prev_mode_ff <= {res_cfg_ff, stream_ff, burst_en_ff};
        end
    end

    assign restart = (prev_mode_ff != {res_cfg_ff, stream_ff, burst_en_ff}) || soft_rst_ff;

    // Burst sequencer. Triggers are looked at only in the waiting state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= abc_pkg::BS_OFF;
            cnt_ff <= '0;
        end else if (!burst_en_ff) begin
            state_ff <= abc_pkg::BS_OFF;
            cnt_ff <= '0;
        end else if (restart || state_ff == abc_pkg::BS_OFF) begin
            state_ff <= abc_pkg::BS_INIT_LO;
            cnt_ff <= lo_len - abc_pkg::CNT_W'(1);
        end else begin
            unique case (state_ff)
                abc_pkg::BS_INIT_LO, abc_pkg::BS_LO: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - abc_pkg::CNT_W'(1);
                    end else if (stream_ff) begin
                        state_ff <= abc_pkg::BS_HI;
                        cnt_ff <= hi_len - abc_pkg::CNT_W'(1);
                    end else begin
                        state_ff <= abc_pkg::BS_WAIT;
                    end
                end
                abc_pkg::BS_WAIT: begin
                    if (trig_rise) begin
                        state_ff <= abc_pkg::BS_DELAY;
                        cnt_ff <= abc_pkg::CNT_W'(abc_pkg::TRIG_DELAY_CYC - 1);
                    end
                end
                abc_pkg::BS_DELAY: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - abc_pkg::CNT_W'(1);
                    end else begin
                        state_ff <= abc_pkg::BS_HI;
                        cnt_ff <= hi_len - abc_pkg::CNT_W'(1);
                    end
                end
                abc_pkg::BS_HI: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - abc_pkg::CNT_W'(1);
                    end else begin
                        state_ff <= abc_pkg::BS_LO;
                        cnt_ff <= lo_len - abc_pkg::CNT_W'(1);
                    end
                end
                default: begin
                    state_ff <= abc_pkg::BS_OFF;
                end
            endcase
        end
    end

    // Ready is high in the cycle after one in which a trigger would be taken.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_ready <= 1'b0;
        end else begin
            trigger_ready <= (state_ff == abc_pkg::BS_WAIT) && !restart;
        end
    end

    assign core_in[0] = core_a;
    assign core_in[1] = core_b;

    // First-order high-pass: a leaky accumulator tracks DC and is subtracted.
    // Wider shifts give lower cutoff and proportionally longer settling.
    for (genvar ch = 0; ch < 2; ch++) begin : g_dco
        logic signed [31:0] acc_ff;
        logic signed [31:0] err;
        logic [4:0] shift;
        assign shift = 5'(abc_pkg::DCO_SHIFT_BASE) + 5'({dco_bw_ff, 1'b0});
        assign err = {core_in[ch], 16'h0000} - acc_ff;
        assign filt[ch] = dco_en_ff ? core_in[ch] - acc_ff[31:16] : core_in[ch];
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                acc_ff <= 32'sh0;
            end else if (!dco_en_ff) begin
                acc_ff <= 32'sh0;
            end else begin
                acc_ff <= acc_ff + (err >>> shift);
            end
        end
    end

    // Sample stream. Data are retimed here, so phase changes never move frames.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            samp_out <= '0;
        end else begin
            samp_out.data_a <= filt[0];
            samp_out.data_b <= filt[1];
            samp_out.flag <= (state_ff == abc_pkg::BS_HI);
            if (state_ff == abc_pkg::BS_HI) begin
                samp_out.res_bits <= res_cfg_ff ? abc_pkg::RES_HI_CFG1 :
                    abc_pkg::RES_HI_CFG0;
            end else begin
                samp_out.res_bits <= abc_pkg::RES_LO;
            end
        end
    end

    // Hold codes 1..3 map to 3, 7 and 15 cycles; the setting serves both channels.
    assign hold_cyc = (hold_sel_ff == 2'h0) ? 4'h0 :
        4'((5'h02 << hold_sel_ff) - 5'h01);

    abc_ovr_chan u_ovr_a (
        .clk(clk),
        .rst_n(rst_n),
        .enable(!burst_en_ff),
        .thr_code(ovr_thr_ff),
        .hold_cyc(hold_cyc),
        .sample(core_a),
        .ovr_ff(overrange_out_a)
    );

    abc_ovr_chan u_ovr_b (
        .clk(clk),
        .rst_n(rst_n),
        .enable(!burst_en_ff),
        .thr_code(ovr_thr_ff),
        .hold_cyc(hold_cyc),
        .sample(core_b),
        .ovr_ff(overrange_out_b)
    );

    // Phase range spans one sample period: 2 * factor steps.
    assign phase_max = (4'h2 << div_ff) - 4'h1;

    // Clock, phase and driver outputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_divide_factor <= 4'h1;
            phase_select <= 4'h0;
            link_reinit <= 1'b0;
            phase_realign <= 1'b0;
            swing_select <= abc_pkg::RST_SWING;
            deemphasis_select <= abc_pkg::RST_DEEMPH;
        end else begin
            clock_divide_factor <= 4'h1 << div_ff;
            phase_select <= (phase_ff > phase_max) ? phase_max : phase_ff;
            link_reinit <= wr_clk &&
                (reg_req.wdata[abc_pkg::CLK_DIV_LSB +: 2] != div_ff);
            phase_realign <= sref_rise;
            swing_select <= swing_ff;
            deemphasis_select <= deemph_ff;
        end
    end

    sequence s_accept;
        state_ff == abc_pkg::BS_WAIT && trig_rise && !restart && burst_en_ff;
    endsequence

    // The last delay cycle is followed directly by the first high-resolution one.
    sequence s_delay_then_hi;
        state_ff == abc_pkg::BS_DELAY ##1 state_ff == abc_pkg::BS_HI;
    endsequence

    // Four undisturbed cycles after the accept must end in exactly that step.
    chk_trig_delay_hi: assert property (@(posedge clk) disable iff (!rst_n)
        s_accept ##1 (burst_en_ff && !restart)[*4] |-> s_delay_then_hi)
        else $error("trigger delay wrong");

    chk_ready_drops: assert property (@(posedge clk) disable iff (!rst_n)
        s_accept |=> ##1 !trigger_ready) else $error("ready stayed high after trigger");

    chk_trig_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (state_ff == abc_pkg::BS_HI && trig_rise && burst_en_ff && !restart)
        |=> state_ff inside {abc_pkg::BS_HI, abc_pkg::BS_LO})
        else $error("trigger taken in burst");

    chk_stream_nowait: assert property (@(posedge clk) disable iff (!rst_n)
        (burst_en_ff && stream_ff && !restart) |-> state_ff != abc_pkg::BS_WAIT)
        else $error("stream mode waited for trigger");

    chk_hires_width: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(samp_out.flag) |-> samp_out.res_bits ==
        ($past(res_cfg_ff) ? abc_pkg::RES_HI_CFG1 : abc_pkg::RES_HI_CFG0))
        else $error("high-resolution width wrong");

    chk_restart_low: assert property (@(posedge clk) disable iff (!rst_n)
        (burst_en_ff && restart) |=> ##1 !samp_out.flag)
        else $error("no low phase after restart");

    chk_ovr_burst: assert property (@(posedge clk) disable iff (!rst_n)
        burst_en_ff ##1 burst_en_ff |-> !overrange_out_a && !overrange_out_b)
        else $error("over-range active in burst mode");

    chk_div_reinit: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_clk && reg_req.wdata[1:0] != div_ff) |=> link_reinit && clock_divide_factor ==
        $past(clock_divide_factor)) else $error("divider change without link restart");

    chk_sysref_align: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sref_s2_ff) |=> phase_realign ##1 !phase_realign)
        else $error("no realign on sysref");

endmodule // abc_top

// [bench/abc_trig_src.sv]
// Trigger source model that fires only while the converter reports ready.
`timescale 1ns/1ps
module abc_trig_src (
    // Clock
    input wire logic clk,
    // Request from the bench and handshake from the converter
    input wire logic fire,
    input wire logic trigger_ready,
    // Trigger pin
    output logic burst_trigger
);
    // Edges inside a running cycle are discarded, so the source waits for ready.
    always @(posedge clk) begin
        burst_trigger <= fire && trigger_ready;
    end
endmodule // abc_trig_src

// [bench/tb.sv]
// Self-checking bench of the converter back-end control.
`timescale 1ns/1ps
module tb;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic sysref = 1'h0;
    logic fire = 1'h0;
    logic burst_trigger;
    logic trigger_ready;
    logic ova;
    logic ovb;
    logic reinit;
    logic realign;
    logic [31:0] rdata;
    logic [3:0] divf;
    logic [3:0] phs;
    logic [2:0] swing;
    logic [2:0] deemph;
    logic [3:0] hres = 4'h0;
    logic signed [15:0] core_a = 16'h0000;
    logic signed [15:0] core_b = 16'h0000;
    abc_pkg::abc_req_t req = '0;
    abc_pkg::abc_samp_t samp;
    int miscompares = 0;
    int num_checks = 0;
    int nfl = 0;
    int nova = 0;
    int novb = 0;
    int nre = 0;
    int nal = 0;
    int n0 = 0;
    always #50 clk = ~clk;
    abc_top u_dut (.clk(clk), .resetn(resetn), .reg_req(req), .reg_rdata(rdata),
        .burst_trigger(burst_trigger), .sysref(sysref), .core_a(core_a),
        .core_b(core_b), .samp_out(samp), .trigger_ready(trigger_ready),
        .overrange_out_a(ova), .overrange_out_b(ovb), .clock_divide_factor(divf),
        .phase_select(phs), .link_reinit(reinit), .phase_realign(realign),
        .swing_select(swing), .deemphasis_select(deemph));
    abc_trig_src u_src (.clk(clk), .fire(fire), .trigger_ready(trigger_ready),
        .burst_trigger(burst_trigger));
    always @(posedge clk) begin
        if (samp.flag === 1'h1) begin
            nfl <= nfl + 1;
            hres <= samp.res_bits;
        end
        nova <= nova + int'(ova === 1'h1);
        novb <= novb + int'(ovb === 1'h1);
        nre <= nre + int'(reinit === 1'h1);
        nal <= nal + int'(realign === 1'h1);
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge clk);
        req.wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
        @(posedge clk);
        req.rd <= 1'h0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic close_out;
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        repeat (3) @(posedge clk);
        rd(8'h40, 32'h0);
        wr(abc_pkg::OFF_DRV, 32'h65);
        wr(abc_pkg::OFF_CLK, 32'h53);
        repeat (4) @(posedge clk);
        chk("swing", 32'h5, 32'(swing));
        chk("deemph", 32'h6, 32'(deemph));
        chk("divider", 32'h8, 32'(divf));
        chk("phase", 32'h5, 32'(phs));
        chk("reinit", 32'h1, 32'(nre));
        sysref <= 1'h1;
        repeat (8) @(posedge clk);
        chk("realign", 32'h1, 32'(nal));
        // Trigger mode at half duty; the threshold drops to its floor once burst mode holds.
        core_a <= 16'h7FFF;
        wr(abc_pkg::OFF_MODE, 32'h5);
        wr(abc_pkg::OFF_OVR, 32'h100);
        repeat (1100) @(posedge clk);
        rd(abc_pkg::OFF_STATUS, 32'h2);
        chk("hi before trig", 32'h0, 32'(nfl));
        fire <= 1'h1;
        repeat (20) @(posedge clk) if (trigger_ready === 1'h0) fire <= 1'h0;
        #1 chk("ready low", 32'h0, 32'(trigger_ready));
        repeat (2100) @(posedge clk);
        chk("hi len", 32'd1024, 32'(nfl));
        chk("hi res", 32'hC, 32'(hres));
        rd(abc_pkg::OFF_STATUS, 32'h2);
        // Stream mode at quarter duty with the trigger pin ignored.
        n0 = nfl;
        wr(abc_pkg::OFF_MODE, 32'h3);
        repeat (4500) @(posedge clk);
        chk("stream hi", 32'd1024, 32'(nfl - n0));
        chk("stream res", 32'hE, 32'(hres));
        chk("ovr burst", 32'h0, 32'(nova));
        chk("data a", 32'h7FFF, 32'(samp.data_a));
        // Over-range: full-scale threshold with no hold, then the floor with hold three.
        core_a <= 16'h0000;
        wr(abc_pkg::OFF_MODE, 32'h0);
        wr(abc_pkg::OFF_OVR, 32'h0FF);
        @(posedge clk);
        core_a <= 16'h8000;
        @(posedge clk);
        core_a <= 16'h0000;
        repeat (4) @(posedge clk);
        chk("ovr zero hold", 32'h1, 32'(nova));
        wr(abc_pkg::OFF_OVR, 32'h100);
        @(posedge clk);
        core_a <= 16'sd200;
        @(posedge clk);
        core_a <= 16'h0000;
        core_b <= -16'sd300;
        @(posedge clk);
        core_b <= 16'h0000;
        repeat (10) @(posedge clk);
        chk("ovr hold", 32'h5, 32'(nova));
        chk("ovr b", 32'h4, 32'(novb));
        close_out;
    end
endmodule // tb
